// ==== hw/brk_pkg.sv ====
// Shared constants, types and helpers for the address breakpoint unit
package brk_pkg;

  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_BP_HIGH  = 8'h04;
  localparam logic [7:0] OFS_BP_LOW   = 8'h08;
  localparam logic [7:0] OFS_EXIT     = 8'h0C;
  localparam logic [7:0] OFS_FLAG_CLR = 8'h10;
  localparam logic [7:0] OFS_EV_STAT  = 8'h14;
  localparam logic [7:0] OFS_EV_CLR   = 8'h18;
  localparam logic [7:0] OFS_EV_EN    = 8'h1C;

  // Field positions
  localparam int BIT_MATCH_EN = 7;
  localparam int BIT_ACTIVE   = 6;
  localparam int BIT_EXIT     = 1;
  localparam int BIT_CLR_EN   = 7;
  localparam int EV_MATCH     = 0;
  localparam int EV_SOFT      = 1;
  localparam int EV_EXIT      = 2;
  localparam int EV_W         = 3;

  // Values after reset
  localparam logic [7:0]      RST_BYTE = 8'h00;
  localparam logic [EV_W-1:0] RST_EV   = 3'h0;
  localparam logic [31:0]     RST_WORD = 32'h0000_0000;

  // Bus encodings
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WRITE = 2'b01,
    ST_RWAIT = 2'b10
  } bus_state_e;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } cpu_bus_s;

  typedef struct packed {
    logic       wr;
    logic [7:0] ofs;
  } acc_s;

  function automatic logic reg_hit(input logic [7:0] ofs, input logic [7:0] target);
    return ofs == target;
  endfunction : reg_hit

endpackage : brk_pkg

// ==== hw/break_match.sv ====
// Registered breakpoint address comparator
`timescale 1ns/1ns
module break_match
  import brk_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // Compare inputs
  input  wire cpu_bus_s    cpu_bus,
  input  wire logic [15:0] bp_addr,
  input  wire logic        match_en,
  // Result
  output logic             match_pulse
);

  wire logic hit_now;

  assign hit_now = match_en & cpu_bus.valid & (cpu_bus.addr == bp_addr);

  // One registered pulse per matching bus cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      match_pulse <= 1'b0;
    end else if (clk_en) begin
      match_pulse <= hit_now;
    end
  end

endmodule : break_match

// ==== hw/address_breakpoint_unit.sv ====
// Address breakpoint unit with AHB-Lite register slave
//
// Summary of operation
// - Match break only on enabled full 16-bit match
// - Match enable bit 7, read/write, reset zero
// - Active flag set on address match
// - Writing one to active flag forces break
// - Reset clears the active flag
// - Breakpoint address from high and low bytes
// - Reset zeroes both address byte registers
// - Exit flag set when break ends low-power
// - Writing zero or reset clears exit flag
// - Status clears in break need clear enable
// - Signal breakpoint request to the CPU core
// - Break state halts both timer counters
//
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module address_breakpoint_unit
  import brk_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // CPU core side
  input  wire cpu_bus_s    cpu_bus,
  input  wire logic        lowpower_mode,
  output logic             break_req,
  output logic             timer_halt,
  output logic             status_clear_allow,
  // Interrupt
  output logic             irq
);

  bus_state_e      state;
  bus_state_e      next_state;
  acc_s            acc;
  logic            match_en;
  logic            active;
  logic            exit_flag;
  logic            clr_in_brk;
  logic [7:0]      bp_hi;
  logic [7:0]      bp_lo;
  logic [EV_W-1:0] ev_status;
  logic [EV_W-1:0] ev_enable;

  wire logic            accept;
  wire logic            wr_phase;
  wire logic            wr_ctrl;
  wire logic            wr_hi;
  wire logic            wr_lo;
  wire logic            wr_exit;
  wire logic            wr_fclr;
  wire logic            wr_evclr;
  wire logic            wr_even;
  wire logic            match_pulse;
  wire logic            soft_break;
  wire logic            any_break;
  wire logic            clear_ok;
  wire logic            next_active;
  wire logic            next_exit;
  wire logic            next_clr;
  wire logic [EV_W-1:0] ev_set;
  wire logic [EV_W-1:0] ev_clr;
  wire logic [EV_W-1:0] next_status;
  wire logic [7:0]      rd_byte;
  wire logic [2:0]      unused_size;

  assign unused_size = hsize;

  // Address phase and data phase decode
  assign accept     = hsel & hready & htrans[1];
  assign next_state = accept ? (hwrite ? ST_WRITE : ST_RWAIT) : ST_IDLE;
  assign wr_phase   = (state == ST_WRITE) & acc.wr;
  assign wr_ctrl    = wr_phase & reg_hit(acc.ofs, OFS_CTRL);
  assign wr_hi      = wr_phase & reg_hit(acc.ofs, OFS_BP_HIGH);
  assign wr_lo      = wr_phase & reg_hit(acc.ofs, OFS_BP_LOW);
  assign wr_exit    = wr_phase & reg_hit(acc.ofs, OFS_EXIT);
  assign wr_fclr    = wr_phase & reg_hit(acc.ofs, OFS_FLAG_CLR);
  assign wr_evclr   = wr_phase & reg_hit(acc.ofs, OFS_EV_CLR);
  assign wr_even    = wr_phase & reg_hit(acc.ofs, OFS_EV_EN);

  // Break sources
  assign soft_break = wr_ctrl & hwdata[BIT_ACTIVE];
  assign any_break  = match_pulse | soft_break;

  // Exit flag and event status clears inside the break state are gated
  assign clear_ok   = ~active | clr_in_brk;

  // Set wins over a same-cycle clear
  assign next_active = match_pulse | (wr_ctrl ? hwdata[BIT_ACTIVE] : active);
  assign next_exit   = (any_break & lowpower_mode)
                     | (exit_flag & ~(wr_exit & ~hwdata[BIT_EXIT] & clear_ok));
  assign next_clr    = wr_fclr ? hwdata[BIT_CLR_EN] : clr_in_brk;

  // Event status: sticky, write-one-to-clear, set wins
  assign ev_set      = {any_break & lowpower_mode, soft_break, match_pulse};
  assign ev_clr      = (wr_evclr & clear_ok) ? hwdata[EV_W-1:0] : RST_EV;
  assign next_status = ev_set | (ev_status & ~ev_clr);

  // Read selection; unmapped and write-only offsets read zero
  assign rd_byte =
      reg_hit(acc.ofs, OFS_CTRL)     ? {match_en, active, 6'h00} :
      reg_hit(acc.ofs, OFS_BP_HIGH)  ? bp_hi :
      reg_hit(acc.ofs, OFS_BP_LOW)   ? bp_lo :
      reg_hit(acc.ofs, OFS_EXIT)     ? {6'h00, exit_flag, 1'b0} :
      reg_hit(acc.ofs, OFS_FLAG_CLR) ? {clr_in_brk, 7'h00} :
      reg_hit(acc.ofs, OFS_EV_STAT)  ? {5'h00, ev_status} :
      reg_hit(acc.ofs, OFS_EV_EN)    ? {5'h00, ev_enable} :
                                       RST_BYTE;

  break_match u_match (
    .core_clk    (core_clk),
    .reset       (reset),
    .clk_en      (clk_en),
    .cpu_bus     (cpu_bus),
    .bp_addr     ({bp_hi, bp_lo}),
    .match_en    (match_en),
    .match_pulse (match_pulse)
  );

  // Bus slave: writes zero-wait, reads one wait state
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state     <= ST_IDLE;
      acc       <= '0;
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
      hrdata    <= RST_WORD;
    end else if (clk_en) begin
      state     <= next_state;
      hreadyout <= ~(accept & ~hwrite);
      hresp     <= HRESP_OKAY;
      if (accept) begin
        acc <= '{wr: hwrite, ofs: haddr[7:0]};
      end
      if (state == ST_RWAIT) begin
        hrdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Control and address registers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      match_en   <= 1'b0;
      bp_hi      <= RST_BYTE;
      bp_lo      <= RST_BYTE;
      clr_in_brk <= 1'b0;
      ev_enable  <= RST_EV;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        match_en <= hwdata[BIT_MATCH_EN];
      end
      if (wr_hi) begin
        bp_hi <= hwdata[7:0];
      end
      if (wr_lo) begin
        bp_lo <= hwdata[7:0];
      end
      if (wr_even) begin
        ev_enable <= hwdata[EV_W-1:0];
      end
      clr_in_brk <= next_clr;
    end
  end

  // Break state, flags and outputs to the core
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      active             <= 1'b0;
      exit_flag          <= 1'b0;
      ev_status          <= RST_EV;
      break_req          <= 1'b0;
      timer_halt         <= 1'b0;
      status_clear_allow <= 1'b1;
      irq                <= 1'b0;
    end else if (clk_en) begin
      active             <= next_active;
      exit_flag          <= next_exit;
      ev_status          <= next_status;
      break_req          <= any_break;
      timer_halt         <= next_active;
      status_clear_allow <= ~next_active | next_clr;
      irq                <= |(ev_status & ev_enable);
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_hit;
    clk_en && cpu_bus.valid && match_en && (cpu_bus.addr == {bp_hi, bp_lo});
  endsequence

  sequence s_soft;
    clk_en && wr_ctrl && hwdata[BIT_ACTIVE];
  endsequence

  sequence s_rd_acc;
    clk_en && accept && !hwrite;
  endsequence

  property p_hit_breaks;
    s_hit ##1 clk_en |=> break_req && active;
  endproperty
  a_hit_breaks: assert property (p_hit_breaks)
    else $error("enabled address match gave no break");

  property p_disabled_quiet;
    clk_en && !match_en |=> !match_pulse;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("match pulse while matching disabled");

  property p_enable_write;
    clk_en && wr_ctrl |=> match_en == $past(hwdata[BIT_MATCH_EN]);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("match enable did not take written value");

  property p_match_sets_active;
    clk_en && match_pulse |=> active && timer_halt;
  endproperty
  a_match_sets_active: assert property (p_match_sets_active)
    else $error("match did not set active flag");

  property p_soft_break;
    s_soft |=> break_req && active;
  endproperty
  a_soft_break: assert property (p_soft_break)
    else $error("software break not raised");

  property p_active_clear;
    clk_en && wr_ctrl && !hwdata[BIT_ACTIVE] && !match_pulse |=> !active;
  endproperty
  a_active_clear: assert property (p_active_clear)
    else $error("active flag not cleared by zero write");

  property p_addr_low_write;
    clk_en && wr_lo |=> bp_lo == $past(hwdata[7:0]);
  endproperty
  a_addr_low_write: assert property (p_addr_low_write)
    else $error("low breakpoint byte not stored");

  property p_exit_set;
    clk_en && any_break && lowpower_mode |=> exit_flag && ev_status[EV_EXIT];
  endproperty
  a_exit_set: assert property (p_exit_set)
    else $error("exit flag not set by break in low-power mode");

  property p_clear_blocked;
    clk_en && wr_exit && !hwdata[BIT_EXIT] && active && !clr_in_brk
      |=> exit_flag == $past(exit_flag) || $past(any_break);
  endproperty
  a_clear_blocked: assert property (p_clear_blocked)
    else $error("exit flag cleared in break without clear enable");

  property p_halt_follows;
    timer_halt == active;
  endproperty
  a_halt_follows: assert property (p_halt_follows)
    else $error("timer halt differs from break state");

  property p_read_wait;
    s_rd_acc |=> !hreadyout ##1 (hreadyout || !$past(clk_en));
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read data phase not one wait state");

  property p_addr_high_write;
    clk_en && wr_hi |=> bp_hi == $past(hwdata[7:0]);
  endproperty
  a_addr_high_write: assert property (p_addr_high_write)
    else $error("high breakpoint byte not stored");

  property p_exit_clear;
    clk_en && wr_exit && !hwdata[BIT_EXIT] && clear_ok && !any_break |=> !exit_flag;
  endproperty
  a_exit_clear: assert property (p_exit_clear)
    else $error("exit flag not cleared by zero write");

  property p_event_clear_gate;
    clk_en && wr_evclr && !clear_ok |=> (ev_status & $past(ev_status)) == $past(ev_status);
  endproperty
  a_event_clear_gate: assert property (p_event_clear_gate)
    else $error("event status cleared in break without clear enable");

  property p_irq_level;
    clk_en |=> irq == $past(|(ev_status & ev_enable));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt line does not follow enabled status");

endmodule : address_breakpoint_unit

// ==== verification/cpu_core_model.sv ====
// Behavioural CPU core that fetches addresses and sleeps
`timescale 1ns/1ns
module cpu_core_model
  import brk_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Bench control
  input  wire logic        fetch,
  input  wire logic [15:0] fetch_addr,
  input  wire logic        sleep,
  // Block side
  input  wire logic        break_req,
  output cpu_bus_s         cpu_bus,
  output logic             lowpower_mode,
  output logic [7:0]       break_count
);
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cpu_bus       <= '0;
      lowpower_mode <= 1'b0;
      break_count   <= 8'h00;
    end else begin
      // Idle address keeps toggling so it never looks stable
      cpu_bus.valid <= fetch;
      cpu_bus.addr  <= fetch ? fetch_addr : ~cpu_bus.addr;
      if (break_req) begin
        lowpower_mode <= 1'b0;
      end else if (sleep) begin
        lowpower_mode <= 1'b1;
      end
      break_count <= break_count + {7'h00, break_req};
    end
  end
endmodule : cpu_core_model

// ==== verification/tb.sv ====
// Register level testbench for the address breakpoint unit
`timescale 1ns/1ns
module tb;
  import brk_pkg::*;
  logic core_clk = 0, reset = 1, hsel = 1, hwrite = 0, fetch = 0, sleep = 0, clk_en = 1;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0]  htrans = 0;
  logic [15:0] fetch_addr = 0;
  logic [7:0]  break_count;
  logic        hreadyout, hresp, break_req, timer_halt, status_clear_allow, irq, lowpower_mode;
  cpu_bus_s    cpu_bus;
  int          bad_count = 0, total_checks = 0;

  always #5 core_clk = ~core_clk;

  address_breakpoint_unit address_breakpoint_unit_inst (.core_clk(core_clk), .reset(reset),
    .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cpu_bus(cpu_bus), .lowpower_mode(lowpower_mode),
    .break_req(break_req), .timer_halt(timer_halt),
    .status_clear_allow(status_clear_allow), .irq(irq));

  cpu_core_model cpu_core_model_inst (.core_clk(core_clk), .reset(reset), .fetch(fetch),
    .fetch_addr(fetch_addr), .sleep(sleep), .break_req(break_req), .cpu_bus(cpu_bus),
    .lowpower_mode(lowpower_mode), .break_count(break_count));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge core_clk);
    htrans <= 2'b10;
    haddr  <= {24'h00_0000, a};
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, {24'h00_0000, d}, q);
  endtask : wr

  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    total_checks++;
    if (q !== {24'h00_0000, e}) begin
      bad_count++;
      $display("FAIL %0t read %h got %h want %h", $time, a, q, e);
    end
    chk_sig(hresp, HRESP_OKAY);
  endtask : chk_reg

  task automatic chk_sig(input logic g, input logic e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %0t signal got %b want %b", $time, g, e);
    end
  endtask : chk_sig

  task automatic go(input logic [15:0] a);
    @(posedge core_clk);
    fetch      <= 1'b1;
    fetch_addr <= a;
    @(posedge core_clk);
    fetch <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask : go

  initial begin
    #100000;
    bad_count++;
    complete_run();
  end

  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    chk_reg(OFS_CTRL, 8'h00);
    chk_reg(OFS_BP_HIGH, 8'h00);
    chk_reg(OFS_BP_LOW, 8'h00);
    chk_reg(OFS_EXIT, 8'h00);
    wr(OFS_BP_HIGH, 8'h12);
    wr(OFS_BP_LOW, 8'h34);
    chk_reg(OFS_BP_HIGH, 8'h12);
    chk_reg(OFS_BP_LOW, 8'h34);
    go(16'h1234);
    chk_sig(break_count === 8'h00, 1'b1);
    wr(OFS_CTRL, 8'h80);
    chk_reg(OFS_CTRL, 8'h80);
    go(16'h1235);
    go(16'h1334);
    chk_sig(break_count === 8'h00, 1'b1);
    go(16'h1234);
    chk_sig(break_count === 8'h01, 1'b1);
    chk_reg(OFS_CTRL, 8'hC0);
    chk_sig(timer_halt, 1'b1);
    chk_sig(status_clear_allow, 1'b0);
    chk_reg(OFS_EV_STAT, 8'h01);
    wr(OFS_EV_EN, 8'h07);
    chk_reg(OFS_EV_EN, 8'h07);
    chk_sig(irq, 1'b1);
    wr(OFS_EV_CLR, 8'h07);
    chk_reg(OFS_EV_STAT, 8'h01);
    wr(OFS_FLAG_CLR, 8'h80);
    chk_reg(OFS_FLAG_CLR, 8'h80);
    chk_sig(status_clear_allow, 1'b1);
    wr(OFS_EV_CLR, 8'h07);
    chk_reg(OFS_EV_STAT, 8'h00);
    chk_sig(irq, 1'b0);
    wr(OFS_CTRL, 8'h80);
    chk_reg(OFS_CTRL, 8'h80);
    chk_sig(timer_halt, 1'b0);
    wr(OFS_CTRL, 8'hC0);
    repeat (3) @(posedge core_clk);
    chk_sig(break_count === 8'h02, 1'b1);
    chk_reg(OFS_CTRL, 8'hC0);
    chk_reg(OFS_EV_STAT, 8'h02);
    wr(OFS_CTRL, 8'h80);
    wr(OFS_FLAG_CLR, 8'h00);
    chk_reg(OFS_EXIT, 8'h00);
    @(posedge core_clk);
    sleep <= 1'b1;
    @(posedge core_clk);
    sleep <= 1'b0;
    go(16'h1234);
    chk_sig(lowpower_mode, 1'b0);
    chk_reg(OFS_EXIT, 8'h02);
    chk_reg(OFS_EV_STAT, 8'h07);
    wr(OFS_EXIT, 8'h00);
    chk_reg(OFS_EXIT, 8'h02);
    wr(OFS_FLAG_CLR, 8'h80);
    wr(OFS_EXIT, 8'h00);
    chk_reg(OFS_EXIT, 8'h00);
    // Match offered while frozen must be lost
    clk_en <= 1'b0;
    go(16'h1234);
    clk_en <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk_sig(break_count === 8'h03, 1'b1);
    wr(8'h40, 8'hFF);
    chk_reg(8'h40, 8'h00);
    chk_reg(OFS_CTRL, 8'hC0);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    chk_reg(OFS_CTRL, 8'h00);
    chk_reg(OFS_BP_HIGH, 8'h00);
    chk_reg(OFS_BP_LOW, 8'h00);
    chk_sig(timer_halt, 1'b0);
    complete_run();
  end
endmodule : tb
